// ===== rtl/cdiv_cfg_regs.sv
// Serial-programmed configuration register bank of the dual-bank clock divider
`include "cdiv_consts.svh"
`default_nettype none
module cdiv_cfg_regs (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic SER_CLK,
   input wire logic SER_DATA,
   input wire logic SER_LATCH_ENABLE,
   output logic POWERDOWN,
   output logic [3:0] GROUP_POWERDOWN,
   output logic [1:0] CLKIN_BUF_SEL,
   output logic [2:0] CLKIN0_DIV,
   output logic [1:0] CLKIN0_MUX,
   output logic [2:0] CLKIN1_DIV,
   output logic [1:0] CLKIN1_MUX,
   output logic [55:0] OUTPUT_FORMAT,
   output logic [5:0] ANALOG_DELAY,
   output cdiv_pkg::div_cfg_t DIV_CFG,
   output cdiv_pkg::sync_cfg_t SYNC_CFG,
   output logic SYNC_START_A,
   output logic SYNC_START_B,
   output logic SERIAL_WRITE_LOCK,
   output logic SOFT_RESET_PENDING
);
   logic sclk_s;
   logic sdat_s;
   logic sle_s;
   logic sclk_d_r;
   logic sle_d_r;
   logic [31:0] shift_r;
   logic [31:0] reg_r [0:6];
   logic [31:0] wdata;
   logic [3:0] waddr;
   logic commit;
   logic locked;
   logic sclk_rise;
   cdiv_pkg::shift_state_t state_r;
   cdiv_pkg::shift_state_t state_nxt;
   logic [6:0] wr_en;
   logic accept;
   // Power-on formats, split into the two serial registers
   localparam logic [31:0] fmt_lo_def = `RST_OUTPUT_FORMAT_LOW;
   localparam logic [31:0] fmt_hi_def = `RST_OUTPUT_FORMAT_HIGH;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin sampling
   cdiv_sync2 u_sync_clk (
      .clk(REF_CLK),
      .rst_n(RSTN),
      .ce(CE),
      .rst_val(1'b0),
      .d(SER_CLK),
      .q(sclk_s)
   );
   cdiv_sync2 u_sync_dat (
      .clk(REF_CLK),
      .rst_n(RSTN),
      .ce(CE),
      .rst_val(1'b0),
      .d(SER_DATA),
      .q(sdat_s)
   );
   // Latch pin idles high between words; a high reset value keeps release from faking a commit
   cdiv_sync2 u_sync_le (
      .clk(REF_CLK),
      .rst_n(RSTN),
      .ce(CE),
      .rst_val(1'b1),
      .d(SER_LATCH_ENABLE),
      .q(sle_s)
   );

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         sclk_d_r <= 1'b0;
         sle_d_r <= 1'b1;
      end else if (CE) begin
         sclk_d_r <= sclk_s;
         sle_d_r <= sle_s;
      end
   end

   // Edge detectors on the synchronised pins
   assign sclk_rise = sclk_s & ~sclk_d_r;
   assign commit = sle_s & ~sle_d_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial shifter, MSB first; only the last 32 bits before the latch count
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         cdiv_pkg::SH_IDLE: begin
            if (sclk_rise) begin
               state_nxt = cdiv_pkg::SH_SHIFT;
            end
         end
         cdiv_pkg::SH_SHIFT: begin
            if (commit) begin
               state_nxt = cdiv_pkg::SH_HOLD;
            end
         end
         cdiv_pkg::SH_HOLD: begin
            if (!sle_s) begin
               state_nxt = cdiv_pkg::SH_IDLE;
            end
         end
         default: begin
            state_nxt = cdiv_pkg::SH_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         state_r <= cdiv_pkg::SH_IDLE;
      end else if (CE) begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         shift_r <= 32'h00000000;
      // A word ends at the latch; clock pulses while it is high are ignored
      end else if (CE && sclk_rise && !sle_s && state_r != cdiv_pkg::SH_HOLD) begin
         shift_r <= {shift_r[30:0], sdat_s};
      end
   end

   assign wdata = shift_r;
   assign waddr = shift_r[3:0];
   assign locked = reg_r[6][`BIT_LOCK];
   assign accept = commit && !locked;

   ////////////////////////////////////////////////////////////////////////////////
   // Write strobes: one per register, for an accepted commit; the lock register strobe follows every commit
   always_comb begin
      wr_en = 7'h00;
      case (waddr)
         `ADDR_GLOBAL_CONTROL: begin
            wr_en[0] = accept;
         end
         `ADDR_OUTPUT_FORMAT_LOW: begin
            wr_en[1] = accept;
         end
         `ADDR_OUTPUT_FORMAT_HIGH: begin
            wr_en[2] = accept;
         end
         `ADDR_DELAY_SYNC_CONTROL: begin
            wr_en[3] = accept;
         end
         `ADDR_DIGITAL_DELAY: begin
            wr_en[4] = accept;
         end
         `ADDR_GROUP_DIVIDERS: begin
            wr_en[5] = accept;
         end
         `ADDR_WRITE_LOCK: begin
            wr_en[6] = commit;
         end
         default: begin
            wr_en = 7'h00;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register bank
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         reg_r[0] <= `RST_GLOBAL_CONTROL;
         reg_r[1] <= `RST_OUTPUT_FORMAT_LOW;
         reg_r[2] <= `RST_OUTPUT_FORMAT_HIGH;
         reg_r[3] <= `RST_DELAY_SYNC_CONTROL;
         reg_r[4] <= `RST_DIGITAL_DELAY;
         reg_r[5] <= `RST_GROUP_DIVIDERS;
         reg_r[6] <= `RST_WRITE_LOCK;
      end else if (CE && commit) begin
         case (waddr)
            `ADDR_GLOBAL_CONTROL: begin
               if (!locked) begin
                  if (wdata[`BIT_SOFT_RESET]) begin
                     // Defaults everywhere; the reset bit stays up until another write to a mapped address
                     reg_r[0] <= `RST_GLOBAL_CONTROL | 32'h00000010;
                     reg_r[1] <= `RST_OUTPUT_FORMAT_LOW;
                     reg_r[2] <= `RST_OUTPUT_FORMAT_HIGH;
                     reg_r[3] <= `RST_DELAY_SYNC_CONTROL;
                     reg_r[4] <= `RST_DIGITAL_DELAY;
                     reg_r[5] <= `RST_GROUP_DIVIDERS;
                     reg_r[6] <= `RST_WRITE_LOCK;
                  end else begin
                     reg_r[0] <= wdata & `MASK_GLOBAL_CONTROL;
                  end
               end
            end
            `ADDR_OUTPUT_FORMAT_LOW: begin
               reg_r[0][`BIT_SOFT_RESET] <= 1'b0;
               if (!locked) begin
                  reg_r[1] <= wdata & `MASK_OUTPUT_FORMAT_LOW;
               end
            end
            `ADDR_OUTPUT_FORMAT_HIGH: begin
               reg_r[0][`BIT_SOFT_RESET] <= 1'b0;
               if (!locked) begin
                  reg_r[2] <= wdata & `MASK_OUTPUT_FORMAT_HIGH;
               end
            end
            `ADDR_DELAY_SYNC_CONTROL: begin
               reg_r[0][`BIT_SOFT_RESET] <= 1'b0;
               if (!locked) begin
                  reg_r[3] <= wdata & `MASK_DELAY_SYNC_CONTROL;
               end
            end
            `ADDR_DIGITAL_DELAY: begin
               reg_r[0][`BIT_SOFT_RESET] <= 1'b0;
               if (!locked) begin
                  reg_r[4] <= wdata & `MASK_DIGITAL_DELAY;
               end
            end
            `ADDR_GROUP_DIVIDERS: begin
               reg_r[0][`BIT_SOFT_RESET] <= 1'b0;
               if (!locked) begin
                  reg_r[5] <= wdata & `MASK_GROUP_DIVIDERS;
               end
            end
            // The lock register stays writable so the bank can be unlocked
            `ADDR_WRITE_LOCK: begin
               reg_r[0][`BIT_SOFT_RESET] <= 1'b0;
               reg_r[6] <= wdata & `MASK_WRITE_LOCK;
            end
            default: begin
               // Unmapped address: nothing changes
               reg_r[0] <= reg_r[0];
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sync start pulses, one cycle after an accepted commit
   // Auto bits are read as they stood before this write
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         SYNC_START_A <= 1'b0;
         SYNC_START_B <= 1'b0;
      end else if (CE) begin
         SYNC_START_A <= wr_en[5] && reg_r[3][`BIT_AUTO_A];
         SYNC_START_B <= (wr_en[4] || wr_en[5]) && reg_r[3][`BIT_AUTO_B];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registered field outputs
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         POWERDOWN <= 1'b0;
         GROUP_POWERDOWN <= 4'h0;
         CLKIN_BUF_SEL <= 2'h0;
         CLKIN0_DIV <= 3'h2;
         CLKIN0_MUX <= 2'h0;
         CLKIN1_DIV <= 3'h2;
         CLKIN1_MUX <= 2'h0;
         OUTPUT_FORMAT <= {4'h0, fmt_hi_def[27:4], fmt_lo_def[31:4]};
         ANALOG_DELAY <= 6'h00;
         DIV_CFG <= '0;
         SYNC_CFG <= '0;
         SERIAL_WRITE_LOCK <= 1'b0;
         SOFT_RESET_PENDING <= 1'b0;
      end else if (CE) begin
         POWERDOWN <= reg_r[0][`BIT_POWERDOWN];
         GROUP_POWERDOWN <= reg_r[0][`BIT_GROUP_PD_LO +: 4];
         CLKIN_BUF_SEL <= reg_r[0][11:10];
         CLKIN0_DIV <= reg_r[0][16:14];
         CLKIN0_MUX <= reg_r[0][18:17];
         CLKIN1_DIV <= reg_r[0][21:19];
         CLKIN1_MUX <= reg_r[0][23:22];
         // Top nibble has no field behind it
         OUTPUT_FORMAT <= {4'h0, reg_r[2][27:4], reg_r[1][31:4]};
         ANALOG_DELAY <= reg_r[3][9:4];
         DIV_CFG.group_a_divider <= reg_r[5][`BIT_DIV_A_LO +: 3];
         DIV_CFG.group_b_divider <= reg_r[5][`BIT_DIV_B_LO +: 3];
         DIV_CFG.group_c_divider <= reg_r[5][`BIT_DIV_C_LO +: 3];
         DIV_CFG.late_pair_divider <= reg_r[5][`BIT_LATE_DIV_LO +: 11];
         DIV_CFG.out12_delay_select <= reg_r[5][`BIT_SEL12];
         DIV_CFG.out13_delay_select <= reg_r[5][`BIT_SEL13];
         DIV_CFG.late_pair_digital_delay <= reg_r[4][`BIT_DDLY_LO +: 10];
         DIV_CFG.late_pair_half_shift <= reg_r[3][`BIT_HALF_SHIFT];
         SYNC_CFG.sync_a_polarity <= reg_r[3][`BIT_SYNC_A_POL];
         SYNC_CFG.sync_b_polarity <= reg_r[3][`BIT_SYNC_B_POL];
         SYNC_CFG.sync_qualify_field <= reg_r[3][`BIT_SYNC_QUAL_LO +: 2];
         SYNC_CFG.sync_exempt <= reg_r[3][`BIT_EXEMPT_LO +: 4];
         SYNC_CFG.fixed_offset <= reg_r[3][`BIT_OFFSET_LO +: 3];
         SYNC_CFG.fast_sync_a <= reg_r[3][`BIT_FAST_A];
         SYNC_CFG.fast_sync_b <= reg_r[3][`BIT_FAST_B];
         SERIAL_WRITE_LOCK <= locked;
         SOFT_RESET_PENDING <= reg_r[0][`BIT_SOFT_RESET];
      end
   end
endmodule
`default_nettype wire

// ===== rtl/cdiv_consts.svh
// Offsets, field positions, reset values and write masks of the divider config bank
`ifndef CDIV_CONSTS_SVH
`define CDIV_CONSTS_SVH
`define ADDR_GLOBAL_CONTROL 4'h0
`define ADDR_OUTPUT_FORMAT_LOW 4'h1
`define ADDR_OUTPUT_FORMAT_HIGH 4'h2
`define ADDR_DELAY_SYNC_CONTROL 4'h3
`define ADDR_DIGITAL_DELAY 4'h4
`define ADDR_GROUP_DIVIDERS 4'h5
`define ADDR_WRITE_LOCK 4'hF
`define RST_GLOBAL_CONTROL 32'h00108000
`define RST_OUTPUT_FORMAT_LOW 32'h11112490
`define RST_OUTPUT_FORMAT_HIGH 32'h01111110
`define RST_DELAY_SYNC_CONTROL 32'h0630C000
`define RST_DIGITAL_DELAY 32'h00000050
`define RST_GROUP_DIVIDERS 32'h00020490
`define RST_WRITE_LOCK 32'h00000000
`define MASK_GLOBAL_CONTROL 32'h00FFCFF0
`define MASK_OUTPUT_FORMAT_LOW 32'hFFFFFFF0
`define MASK_OUTPUT_FORMAT_HIGH 32'h0FFFFFF0
`define MASK_DELAY_SYNC_CONTROL 32'h07FFDFF0
`define MASK_DIGITAL_DELAY 32'h00003FF0
`define MASK_GROUP_DIVIDERS 32'h0FFE7FF0
`define MASK_WRITE_LOCK 32'h00000010
`define BIT_SOFT_RESET 4
`define BIT_POWERDOWN 5
`define BIT_GROUP_PD_LO 6
`define BIT_HALF_SHIFT 10
`define BIT_SYNC_QUAL_LO 11
`define BIT_SYNC_A_POL 14
`define BIT_SYNC_B_POL 15
`define BIT_EXEMPT_LO 16
`define BIT_OFFSET_LO 20
`define BIT_FAST_A 23
`define BIT_FAST_B 24
`define BIT_AUTO_A 25
`define BIT_AUTO_B 26
`define BIT_DDLY_LO 4
`define BIT_DIV_A_LO 4
`define BIT_DIV_B_LO 7
`define BIT_DIV_C_LO 10
`define BIT_SEL12 13
`define BIT_SEL13 14
`define BIT_LATE_DIV_LO 17
`define BIT_LOCK 4
`define WORD_BITS 32
`endif

// ===== rtl/cdiv_pkg.sv
// Types shared by the divider configuration bank
`default_nettype none
package cdiv_pkg;
   typedef struct packed {
      logic [2:0] group_a_divider;
      logic [2:0] group_b_divider;
      logic [2:0] group_c_divider;
      logic [10:0] late_pair_divider;
      logic out12_delay_select;
      logic out13_delay_select;
      logic [9:0] late_pair_digital_delay;
      logic late_pair_half_shift;
   } div_cfg_t;
   typedef struct packed {
      logic sync_a_polarity;
      logic sync_b_polarity;
      logic [1:0] sync_qualify_field;
      logic [3:0] sync_exempt;
      logic [2:0] fixed_offset;
      logic fast_sync_a;
      logic fast_sync_b;
   } sync_cfg_t;
   typedef enum logic [1:0] {
      SH_IDLE = 2'b00,
      SH_SHIFT = 2'b01,
      SH_HOLD = 2'b10
   } shift_state_t;
endpackage
`default_nettype wire

// ===== rtl/cdiv_sync2.sv
// Two-flop synchroniser for one pin level
`default_nettype none
module cdiv_sync2 (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic rst_val,
   input wire logic d,
   output logic q
);
   logic meta_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= rst_val;
         q <= rst_val;
      end else if (ce) begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ===== bench/cdiv_cfg_regs_properties.sv
// Concurrent checks on the ports of the divider configuration bank
`default_nettype none
module cdiv_cfg_regs_properties (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic SER_LATCH_ENABLE,
   input wire logic POWERDOWN,
   input wire logic [3:0] GROUP_POWERDOWN,
   input wire logic [2:0] CLKIN0_DIV,
   input wire logic [2:0] CLKIN1_DIV,
   input wire logic [55:0] OUTPUT_FORMAT,
   input wire cdiv_pkg::div_cfg_t DIV_CFG,
   input wire cdiv_pkg::sync_cfg_t SYNC_CFG,
   input wire logic SYNC_START_A,
   input wire logic SYNC_START_B,
   input wire logic SERIAL_WRITE_LOCK,
   input wire logic SOFT_RESET_PENDING
);
   localparam cdiv_pkg::div_cfg_t div_def = '{3'h1, 3'h1, 3'h1, 11'h001, 1'h0, 1'h0, 10'h005, 1'h0};
   localparam cdiv_pkg::sync_cfg_t sync_def = '{1'h1, 1'h1, 2'h0, 4'h0, 3'h3, 1'h0, 1'h0};
   logic le_seen_r;
   logic [3:0] le_age_r;
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) le_seen_r <= 1'b1;
      else le_seen_r <= SER_LATCH_ENABLE;
   end
   // Cycles since the latch pin was last seen rising, saturating
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) le_age_r <= 4'hF;
      else if (SER_LATCH_ENABLE && !le_seen_r) le_age_r <= 4'h0;
      else if (le_age_r != 4'hF) le_age_r <= le_age_r + 4'h1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RSTN);
   sequence defaults_s;
      DIV_CFG == div_def && SYNC_CFG == sync_def && !POWERDOWN && GROUP_POWERDOWN == 4'h0
         && CLKIN0_DIV == 3'h2 && CLKIN1_DIV == 3'h2 && OUTPUT_FORMAT[15:12] == 4'h1
         && !SERIAL_WRITE_LOCK;
   endsequence
   sequence fresh_commit_s;
      le_age_r inside {[4'h2:4'h8]};
   endsequence
   a_start_a_pulse: assert property (SYNC_START_A |=> !SYNC_START_A)
      else $error("sync start a longer than one cycle");
   a_start_b_pulse: assert property (SYNC_START_B |-> fresh_commit_s ##1 !SYNC_START_B)
      else $error("sync start b not a single pulse after a latch");
   a_start_after_latch: assert property (SYNC_START_A |-> fresh_commit_s)
      else $error("sync start a without a recent latch");
   a_change_after_latch: assert property (($past(RSTN, 2) && ($changed(DIV_CFG)
      || $changed(SYNC_CFG) || $changed(OUTPUT_FORMAT))) |-> fresh_commit_s)
      else $error("configuration changed without a latch");
   a_lock_blocks_writes: assert property ((SERIAL_WRITE_LOCK && $past(SERIAL_WRITE_LOCK))
      |-> $stable(DIV_CFG) && !SYNC_START_A && !SYNC_START_B)
      else $error("locked bank took a write");
   a_powerdown_keeps: assert property ($rose(POWERDOWN) |-> $stable(DIV_CFG)
      && $stable(SYNC_CFG) && $stable(OUTPUT_FORMAT))
      else $error("powerdown disturbed other settings");
   a_release_defaults: assert property ($rose(RSTN) |=> defaults_s)
      else $error("defaults missing after reset");
   a_soft_reset_defaults: assert property ($rose(SOFT_RESET_PENDING) |-> defaults_s)
      else $error("soft reset did not load defaults");
   a_pending_clear_cause: assert property ($fell(SOFT_RESET_PENDING) |-> fresh_commit_s)
      else $error("soft reset flag cleared without a write");
endmodule
bind cdiv_cfg_regs cdiv_cfg_regs_properties u_cdiv_cfg_regs_properties (.REF_CLK, .RSTN,
   .SER_LATCH_ENABLE, .POWERDOWN, .GROUP_POWERDOWN, .CLKIN0_DIV, .CLKIN1_DIV, .OUTPUT_FORMAT,
   .DIV_CFG, .SYNC_CFG, .SYNC_START_A, .SYNC_START_B, .SERIAL_WRITE_LOCK, .SOFT_RESET_PENDING);
`default_nettype wire

// ===== bench/cdiv_host_model.sv
// Host side of the three-wire programming link
`default_nettype none
module cdiv_host_model (
   output logic ser_clk,
   output logic ser_data,
   output logic ser_latch_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_latch_enable = 1'b1;
   end
   // Clock rests low between words; data turns over once the latch has fired
   task automatic send(input logic [31:0] word);
      ser_latch_enable = 1'b0;
      #480;
      for (int i = 31; i >= 0; i--) begin
         ser_data = word[i];
         #160 ser_clk = 1'b1;
         #160 ser_clk = 1'b0;
      end
      #160 ser_latch_enable = 1'b1;
      #160 ser_data = ~word[0];
   endtask
endmodule
`default_nettype wire

// ===== bench/cdiv_cfg_regs_tb.sv
// Self-checking bench for the divider configuration bank
`include "cdiv_consts.svh"
`default_nettype none
module cdiv_cfg_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   wire ser_clk, ser_data, ser_le;
   logic powerdown, start_a, start_b, lock, pending;
   logic [3:0] group_pd;
   logic [1:0] buf_sel, in0_mux, in1_mux;
   logic [2:0] in0_div, in1_div;
   logic [55:0] out_fmt;
   logic [5:0] adly;
   cdiv_pkg::div_cfg_t div_cfg;
   cdiv_pkg::sync_cfg_t sync_cfg;
   int error_cnt = 0;
   int tests_run = 0;
   int seen_a, seen_b;
   logic [31:0] sh [16];
   logic [31:0] rst_img [16];
   logic [31:0] mask [16];
   logic [3:0] a;
   logic [27:0] d;
   ////////////////////////////////////////////////////////////////////////////////
   cdiv_cfg_regs u_cdiv_cfg_regs (.REF_CLK(ref_clk), .RSTN(rstn), .CE(ce), .SER_CLK(ser_clk),
      .SER_DATA(ser_data), .SER_LATCH_ENABLE(ser_le), .POWERDOWN(powerdown),
      .GROUP_POWERDOWN(group_pd), .CLKIN_BUF_SEL(buf_sel), .CLKIN0_DIV(in0_div),
      .CLKIN0_MUX(in0_mux), .CLKIN1_DIV(in1_div), .CLKIN1_MUX(in1_mux), .OUTPUT_FORMAT(out_fmt),
      .ANALOG_DELAY(adly), .DIV_CFG(div_cfg), .SYNC_CFG(sync_cfg), .SYNC_START_A(start_a),
      .SYNC_START_B(start_b), .SERIAL_WRITE_LOCK(lock), .SOFT_RESET_PENDING(pending));
   cdiv_host_model u_cdiv_host_model (.ser_clk(ser_clk), .ser_data(ser_data),
      .ser_latch_enable(ser_le));
   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (start_a) seen_a++;
      if (start_b) seen_b++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check_all;
      check("global", {pending, lock, powerdown, group_pd, buf_sel, in0_div, in0_mux, in1_div,
         in1_mux}, {sh[0][4], sh[15][4], sh[0][5], sh[0][9:6], sh[0][11:10], sh[0][16:14],
         sh[0][18:17], sh[0][21:19], sh[0][23:22]});
      check("format", out_fmt, {4'h0, sh[2][27:4], sh[1][31:4]});
      check("delay", {adly, div_cfg}, {sh[3][9:4], sh[5][6:4], sh[5][9:7], sh[5][12:10],
         sh[5][27:17], sh[5][13], sh[5][14], sh[4][13:4], sh[3][10]});
      check("sync", sync_cfg, {sh[3][14], sh[3][15], sh[3][12:11], sh[3][19:16],
         sh[3][22:20], sh[3][23], sh[3][24]});
   endtask
   // One serial write, then shadow update and comparison of every output
   task automatic wr(input logic [3:0] wa, input logic [27:0] wd);
      logic ok;
      int ea;
      int eb;
      ok = (wa == 4'hF) || (wa <= 4'h5 && !sh[15][4]);
      ea = (ok && wa == 4'h5 && sh[3][25]) ? 1 : 0;
      eb = (ok && (wa == 4'h4 || wa == 4'h5) && sh[3][26]) ? 1 : 0;
      seen_a = 0;
      seen_b = 0;
      u_cdiv_host_model.send({wd, wa});
      repeat (12) @(negedge ref_clk);
      if (wa != 4'h0 && (wa <= 4'h5 || wa == 4'hF)) sh[0][4] = 1'b0;
      if (ok && wa == 4'h0 && wd[0]) begin
         sh = rst_img;
         sh[0][4] = 1'b1;
      end else if (ok) begin
         sh[wa] = {wd, wa} & mask[wa];
      end
      check("start_a", seen_a, ea);
      check("start_b", seen_b, eb);
      check_all;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #2_000_000;
      error_cnt++;
      tally_and_finish;
   end
   initial begin
      rst_img = '{default: 32'h0};
      mask = '{default: 32'h0};
      rst_img[0] = `RST_GLOBAL_CONTROL;
      rst_img[1] = `RST_OUTPUT_FORMAT_LOW;
      rst_img[2] = `RST_OUTPUT_FORMAT_HIGH;
      rst_img[3] = `RST_DELAY_SYNC_CONTROL;
      rst_img[4] = `RST_DIGITAL_DELAY;
      rst_img[5] = `RST_GROUP_DIVIDERS;
      mask[0] = `MASK_GLOBAL_CONTROL;
      mask[1] = `MASK_OUTPUT_FORMAT_LOW;
      mask[2] = `MASK_OUTPUT_FORMAT_HIGH;
      mask[3] = `MASK_DELAY_SYNC_CONTROL;
      mask[4] = `MASK_DIGITAL_DELAY;
      mask[5] = `MASK_GROUP_DIVIDERS;
      mask[15] = `MASK_WRITE_LOCK;
      void'($urandom(32'hE2FFE852));
      repeat (20) @(negedge ref_clk);
      rstn = 1'b1;
      @(negedge ref_clk);
      sh = rst_img;
      check_all;
      for (int c = 0; c < 15; c++) wr(4'h2, {4'h0, c[3:0], 20'h11111});
      for (int n = 0; n < 30; n++) begin
         a = 4'($urandom_range(15, 0));
         d = 28'($urandom);
         if (a == 4'h0) d[0] = 1'b0;
         wr(a, d);
      end
      wr(4'hF, 28'h0);
      wr(4'h0, 28'hFFFFFFF);
      wr(4'h9, 28'h1234567);
      wr(4'h1, 28'h2222222);
      wr(4'hF, 28'h0000001);
      wr(4'h5, 28'h0ABCDEF);
      wr(4'h0, 28'h0000001);
      wr(4'hF, 28'h0);
      wr(4'h5, 28'h7654321);
      wr(4'h0, 28'h0000002);
      wr(4'h0, 28'h0);
      // Clock enable low: a whole word passes unseen and nothing moves
      seen_a = 0;
      seen_b = 0;
      ce = 1'b0;
      u_cdiv_host_model.send({28'h0ABCDEF, 4'h5});
      repeat (12) @(negedge ref_clk);
      ce = 1'b1;
      repeat (12) @(negedge ref_clk);
      check("frozen_start", seen_a + seen_b, 0);
      check_all;
      for (int m = 0; m < 4; m++) begin
         wr(4'h3, {5'h0, m[1:0], 21'h0});
         wr(4'h4, 28'($urandom));
         wr(4'h5, 28'($urandom));
      end
      @(negedge ref_clk);
      rstn = 1'b0;
      repeat (20) @(negedge ref_clk);
      rstn = 1'b1;
      @(negedge ref_clk);
      sh = rst_img;
      check_all;
      tally_and_finish;
   end
endmodule
`default_nettype wire
